// ==== core/sdrt_pkg.sv ====
package sdrt_pkg;
  // Clock of the controller and of the memory it drives
  localparam int TCK_NS = 40;
  localparam int CW = 16;
  // Fixed figures of the memory timing
  localparam int TZQCS_NCK = 128;
  localparam int TXPR_MIN_NCK = 5;
  localparam int TXS_EXTRA_NS = 10;
  localparam int TCKESR_EXTRA_NCK = 1;
  localparam int TCKSRE_MIN_NCK = 5;
  localparam int TCKSRE_NS = 10;
  localparam int PL_W = 4;

  // Request and command kinds
  typedef enum logic [3:0] {
    K_NODLL = 4'h0,
    K_DLL = 4'h1,
    K_ZQMRS = 4'h2,
    K_ZQS = 4'h3,
    K_RST_EXIT = 4'h4,
    K_SR_ENTER = 4'h5,
    K_SR_EXIT = 4'h6,
    K_PD_ENTER = 4'h7,
    K_PD_EXIT = 4'h8
  } sdrt_kind_t;

  typedef struct packed {
    logic valid;
    sdrt_kind_t kind;
  } sdrt_req_t;

  typedef struct packed {
    logic abort_en;
    logic par_en;
    logic [PL_W-1:0] par_lat;
  } sdrt_cfg_t;

  typedef struct packed {
    logic cke;
    logic clk_en;
    logic cmd_valid;
    sdrt_kind_t cmd_kind;
  } sdrt_dram_t;

  // Nanoseconds to whole cycles, rounded up, never below one
  function automatic logic [CW-1:0] ns2cyc(input int ns);
    int c;
    c = (ns + TCK_NS - 1) / TCK_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[CW-1:0];
  endfunction

  function automatic logic [CW-1:0] max16(input logic [CW-1:0] a, input logic [CW-1:0] b);
    return (a > b) ? a : b;
  endfunction
endpackage

// ==== core/sdrt_ctrl.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - Short ZQ blocks all commands 128 cycles
// - After reset CKE rise wait max(5,tRFC+10ns)
// - After self-refresh exit wait tRFC+10ns
// - Abort mode allows commands after tRFC4+10ns
// - ZQ and MRS wait tRFC4+10ns after exit; here tRFC+10ns unless in abort mode
// - DLL commands wait DLL lock time after exit
// - Self-refresh CKE low at least tCKE+1
// - Parity adds latency to CKE low time
// - Clock valid max(5,10ns) after SR/PD entry
// - Parity adds latency to clock valid time
// - Stable clock before self-refresh exit
module sdrt_ctrl #(
  parameter int TRFC_NS = 350,
  parameter int TRFC4_NS = 160,
  parameter int TDLLK_NCK = 1024,
  parameter int TCKE_NCK = 3,
  parameter int TCKSRX_NCK = 5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // User request side
  input wire sdrt_pkg::sdrt_req_t req,
  output logic req_ready,
  // Static configuration
  input wire sdrt_pkg::sdrt_cfg_t cfg,
  // Toward the memory
  output sdrt_pkg::sdrt_dram_t dram
);
  typedef enum logic [2:0] {
    ST_RST = 3'b000,
    ST_IDLE = 3'b001,
    ST_SR = 3'b010,
    ST_SRX = 3'b011,
    ST_PD = 3'b100
  } sdrt_st_t;

  localparam logic [15:0] ONE = 16'h0001;
  // Cycle counts, every ns figure rounded up
  localparam logic [15:0] C_ZQCS = 16'(sdrt_pkg::TZQCS_NCK);
  localparam logic [15:0] C_XPR = sdrt_pkg::max16(16'(sdrt_pkg::TXPR_MIN_NCK),
    sdrt_pkg::ns2cyc(TRFC_NS + sdrt_pkg::TXS_EXTRA_NS));
  localparam logic [15:0] C_XS = sdrt_pkg::ns2cyc(TRFC_NS + sdrt_pkg::TXS_EXTRA_NS);
  localparam logic [15:0] C_XS4 = sdrt_pkg::ns2cyc(TRFC4_NS + sdrt_pkg::TXS_EXTRA_NS);
  localparam logic [15:0] C_XSDLL = 16'(TDLLK_NCK);
  localparam logic [15:0] C_CKESR = 16'(TCKE_NCK + sdrt_pkg::TCKESR_EXTRA_NCK);
  localparam logic [15:0] C_CKSRE = sdrt_pkg::max16(16'(sdrt_pkg::TCKSRE_MIN_NCK),
    sdrt_pkg::ns2cyc(sdrt_pkg::TCKSRE_NS));
  localparam logic [15:0] C_CKSRX = 16'(TCKSRX_NCK);

  sdrt_st_t st_r, st_nxt;
  logic [15:0] t_any_r, t_any_nxt, t_fast_r, t_fast_nxt, t_dll_r, t_dll_nxt;
  logic [15:0] ph_r, ph_nxt;
  logic cke_r, cke_nxt, clk_r, clk_nxt, cv_r, cv_nxt;
  sdrt_pkg::sdrt_kind_t ck_r, ck_nxt;
  logic [15:0] pl_add, ckesr_c, cksre_c;
  logic any_ok, fast_ok, dll_ok, accept;

  // Parity stretches both the CKE-low and the clock-valid windows
  assign pl_add = cfg.par_en ? {12'h000, cfg.par_lat} : 16'h0000;
  assign ckesr_c = C_CKESR + pl_add;
  assign cksre_c = C_CKSRE + pl_add;
  // A timer at one or zero lets the next command out next cycle
  assign any_ok = (t_any_r <= ONE);
  assign fast_ok = (t_fast_r <= ONE);
  assign dll_ok = (t_dll_r <= ONE);
  assign accept = req.valid && req_ready;
  assign dram = '{cke: cke_r, clk_en: clk_r, cmd_valid: cv_r, cmd_kind: ck_r};

  // Which request may go now; combinational handshake
  always_comb begin
    req_ready = 1'b0;
    case (st_r)
      ST_RST: begin
        req_ready = (req.kind == sdrt_pkg::K_RST_EXIT);
      end
      ST_IDLE: begin
        case (req.kind)
          sdrt_pkg::K_NODLL, sdrt_pkg::K_SR_ENTER, sdrt_pkg::K_PD_ENTER: begin
            req_ready = any_ok;
          end
          sdrt_pkg::K_DLL: begin
            req_ready = any_ok && dll_ok;
          end
          sdrt_pkg::K_ZQMRS, sdrt_pkg::K_ZQS: begin
            req_ready = any_ok && fast_ok;
          end
          default: begin
            req_ready = 1'b0;
          end
        endcase
      end
      ST_SR: begin
        // Exit only once CKE has been low long enough and clock hold is over
        req_ready = (req.kind == sdrt_pkg::K_SR_EXIT) && (ph_r >= ckesr_c)
          && (ph_r >= cksre_c);
      end
      ST_PD: begin
        req_ready = (req.kind == sdrt_pkg::K_PD_EXIT) && (ph_r >= cksre_c);
      end
      default: begin
        req_ready = 1'b0;
      end
    endcase
  end

  // Sequencer next state; timers count down and saturate at zero
  always_comb begin
    st_nxt = st_r;
    t_any_nxt = (t_any_r != 16'h0000) ? t_any_r - ONE : t_any_r;
    t_fast_nxt = (t_fast_r != 16'h0000) ? t_fast_r - ONE : t_fast_r;
    t_dll_nxt = (t_dll_r != 16'h0000) ? t_dll_r - ONE : t_dll_r;
    ph_nxt = (ph_r != 16'hFFFF) ? ph_r + ONE : ph_r;
    cke_nxt = cke_r;
    clk_nxt = clk_r;
    cv_nxt = 1'b0;
    ck_nxt = ck_r;
    if (accept && (st_r != ST_SR)) begin
      cv_nxt = 1'b1;
      ck_nxt = req.kind;
    end
    case (st_r)
      ST_RST: begin
        if (accept) begin
          cke_nxt = 1'b1;
          t_any_nxt = C_XPR;
          st_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (accept) begin
          if (req.kind == sdrt_pkg::K_ZQS) begin
            t_any_nxt = C_ZQCS;
          end else if (req.kind == sdrt_pkg::K_SR_ENTER) begin
            cke_nxt = 1'b0;
            ph_nxt = ONE;
            st_nxt = ST_SR;
          end else if (req.kind == sdrt_pkg::K_PD_ENTER) begin
            cke_nxt = 1'b0;
            ph_nxt = ONE;
            st_nxt = ST_PD;
          end
        end
      end
      ST_SR: begin
        // Clock may stop only after the hold window, saving power in refresh
        if (ph_r >= cksre_c) begin
          clk_nxt = 1'b0;
        end
        if (accept) begin
          clk_nxt = 1'b1;
          ph_nxt = ONE;
          st_nxt = ST_SRX;
        end
      end
      ST_SRX: begin
        // Clock runs for the stable period before CKE rises
        if (ph_r >= C_CKSRX) begin
          cke_nxt = 1'b1;
          cv_nxt = 1'b1;
          ck_nxt = sdrt_pkg::K_SR_EXIT;
          t_any_nxt = cfg.abort_en ? C_XS4 : C_XS;
          t_fast_nxt = C_XS4;
          t_dll_nxt = C_XSDLL;
          st_nxt = ST_IDLE;
        end
      end
      ST_PD: begin
        if (accept) begin
          cke_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_RST;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RST;
      t_any_r <= 16'h0000;
      t_fast_r <= 16'h0000;
      t_dll_r <= 16'h0000;
      ph_r <= 16'h0000;
      cke_r <= 1'b0;
      clk_r <= 1'b1;
      cv_r <= 1'b0;
      ck_r <= sdrt_pkg::K_NODLL;
    end else begin
      st_r <= st_nxt;
      t_any_r <= t_any_nxt;
      t_fast_r <= t_fast_nxt;
      t_dll_r <= t_dll_nxt;
      ph_r <= ph_nxt;
      cke_r <= cke_nxt;
      clk_r <= clk_nxt;
      cv_r <= cv_nxt;
      ck_r <= ck_nxt;
    end
  end

  // Checker helpers: spacing counters read only by assertions
  logic [15:0] gap_r, gap_nxt, srx_r, srx_nxt, low_r, low_nxt, on_r, on_nxt;
  sdrt_pkg::sdrt_kind_t lk_r, lk_nxt;
  always_comb begin
    gap_nxt = cv_r ? ONE : ((gap_r != 16'hFFFF) ? gap_r + ONE : gap_r);
    lk_nxt = cv_r ? ck_r : lk_r;
    srx_nxt = (cv_r && ck_r == sdrt_pkg::K_SR_EXIT) ? ONE
      : ((srx_r != 16'hFFFF) ? srx_r + ONE : srx_r);
    low_nxt = !cke_r ? ((low_r != 16'hFFFF) ? low_r + ONE : low_r) : 16'h0000;
    on_nxt = clk_r ? ((on_r != 16'hFFFF) ? on_r + ONE : on_r) : 16'h0000;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 16'hFFFF;
      lk_r <= sdrt_pkg::K_NODLL;
      srx_r <= 16'hFFFF;
      low_r <= 16'h0000;
      on_r <= 16'hFFFF;
    end else begin
      gap_r <= gap_nxt;
      lk_r <= lk_nxt;
      srx_r <= srx_nxt;
      low_r <= low_nxt;
      on_r <= on_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  zq_gap_a: assert property (cv_r && lk_r == sdrt_pkg::K_ZQS |-> gap_r >= C_ZQCS)
    else $error("command too soon after short ZQ");
  xpr_wait_a: assert property (cv_r && lk_r == sdrt_pkg::K_RST_EXIT |-> gap_r >= C_XPR)
    else $error("command too soon after reset exit");
  xs_wait_a: assert property (cv_r && !cfg.abort_en && ck_r != sdrt_pkg::K_SR_EXIT
    |-> srx_r >= C_XS)
    else $error("command too soon after self-refresh exit");
  xs_abort_a: assert property (cv_r && cfg.abort_en && ck_r != sdrt_pkg::K_SR_EXIT
    |-> srx_r >= C_XS4)
    else $error("command too soon after exit in abort mode");
  xs_fast_a: assert property (cv_r && (ck_r == sdrt_pkg::K_ZQS
    || ck_r == sdrt_pkg::K_ZQMRS) |-> srx_r >= C_XS4)
    else $error("ZQ or MRS too soon after self-refresh exit");
  xs_dll_a: assert property (cv_r && ck_r == sdrt_pkg::K_DLL |-> srx_r >= C_XSDLL)
    else $error("DLL command before lock time");
  ckesr_low_a: assert property ($rose(cke_r) && ck_r == sdrt_pkg::K_SR_EXIT && !cfg.par_en
    |-> low_r >= C_CKESR)
    else $error("CKE low too short in self refresh");
  ckesr_par_a: assert property ($rose(cke_r) && ck_r == sdrt_pkg::K_SR_EXIT && cfg.par_en
    |-> low_r >= C_CKESR + {12'h000, cfg.par_lat})
    else $error("CKE low too short with parity");
  cksre_hold_a: assert property ($fell(clk_r) && !cfg.par_en |-> low_r >= C_CKSRE)
    else $error("clock stopped too soon after entry");
  cksre_par_a: assert property ($fell(clk_r) && cfg.par_en
    |-> low_r >= C_CKSRE + {12'h000, cfg.par_lat})
    else $error("clock stopped too soon with parity");
  cksrx_stable_a: assert property ($rose(cke_r) && ck_r == sdrt_pkg::K_SR_EXIT
    |-> on_r >= C_CKSRX && $past(clk_r))
    else $error("clock not stable before self-refresh exit");
  srx_start_a: assert property (st_r == ST_SR && accept |=> clk_r ##[1:8] st_r == ST_SRX)
    else $error("exit did not restart the clock");

  zq_seen_c: cover property (cv_r && ck_r == sdrt_pkg::K_ZQS);
  sr_cycle_c: cover property ($fell(clk_r) ##[1:1000] $rose(cke_r));
  pd_exit_c: cover property (cv_r && ck_r == sdrt_pkg::K_PD_EXIT);
  dll_after_c: cover property (cv_r && ck_r == sdrt_pkg::K_DLL && srx_r != 16'hFFFF);
endmodule

// ==== sim/sdrt_dram_model.sv ====
`timescale 1ns/1ns
// Memory side: counts every command that comes sooner than its minimum gap
module sdrt_dram_model #(
  parameter int XPR = 6,
  parameter int XS = 6,
  parameter int XS4 = 5,
  parameter int DLLK = 16,
  parameter int CKESR = 4,
  parameter int CKSRE = 5,
  parameter int CKSRX = 5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Controller outputs and mode
  input wire sdrt_pkg::sdrt_dram_t dram,
  input wire sdrt_pkg::sdrt_cfg_t cfg,
  // Fault count
  output logic [15:0] err
);
  localparam int ZQ = 0;
  localparam int RS = 1;
  localparam int SX = 2;
  localparam int SE = 3;
  localparam int OF = 4;
  int cyc;
  int t[5];
  // Stamps start far back so that the first command is never counted as too soon
  always @(posedge clk_sys or negedge rst_n) begin : watch
    int c;
    int pl;
    int bad;
    sdrt_pkg::sdrt_kind_t k;
    c = cyc + 1;
    pl = cfg.par_en ? int'(cfg.par_lat) : 0;
    k = dram.cmd_kind;
    bad = 0;
    if (!rst_n) begin
      cyc <= 0;
      err <= 16'h0000;
      foreach (t[i]) t[i] <= -999;
    end else begin
      cyc <= c;
      if (!dram.clk_en) begin
        t[OF] <= c;
        if (c - t[SE] < CKSRE + pl) bad++;
      end
      if (dram.cmd_valid) begin
        if (c - t[ZQ] < sdrt_pkg::TZQCS_NCK || c - t[RS] < XPR) bad++;
        if (k == sdrt_pkg::K_SR_EXIT) begin
          // Exit needs the CKE low width and CKSRX whole running cycles before it
          if (c - t[SE] < CKESR + pl || c - t[OF] <= CKSRX || !dram.clk_en) bad++;
          t[SX] <= c;
        end else if (c - t[SX] < (cfg.abort_en ? XS4 : XS)) bad++;
        if ((k == sdrt_pkg::K_ZQS || k == sdrt_pkg::K_ZQMRS) && c - t[SX] < XS4) bad++;
        if (k == sdrt_pkg::K_DLL && c - t[SX] < DLLK) bad++;
        if (k == sdrt_pkg::K_ZQS) t[ZQ] <= c;
        if (k == sdrt_pkg::K_RST_EXIT) t[RS] <= c;
        if (k == sdrt_pkg::K_SR_ENTER || k == sdrt_pkg::K_PD_ENTER) t[SE] <= c;
      end
      err <= err + 16'(bad);
    end
  end
endmodule

// ==== sim/test_sdrt_ctrl.sv ====
`timescale 1ns/1ns
module test_sdrt_ctrl;
  // Gaps in cycles for TRFC_NS=200 and TRFC4_NS=160 at 40 ns
  localparam int XPR = 6;
  localparam int XS = 6;
  localparam int XS4 = 5;
  localparam int DLLK = 16;
  localparam int CKSRE = 5;
  localparam int CKSRX = 5;
  // CKE width long enough that the self-refresh exit has to wait for it
  localparam int CKESR = 14;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  sdrt_pkg::sdrt_req_t req = '0;
  sdrt_pkg::sdrt_cfg_t cfg = '0;
  logic req_ready;
  sdrt_pkg::sdrt_dram_t dram;
  logic [15:0] err;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int last = 0;
  sdrt_ctrl #(.TRFC_NS(200), .TRFC4_NS(160), .TDLLK_NCK(DLLK), .TCKE_NCK(CKESR - 1),
    .TCKSRX_NCK(CKSRX)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
    .req_ready(req_ready), .cfg(cfg), .dram(dram));
  sdrt_dram_model #(.XPR(XPR), .XS(XS), .XS4(XS4), .DLLK(DLLK), .CKESR(CKESR), .CKSRE(CKSRE),
    .CKSRX(CKSRX)) u_mem (.clk_sys(clk_sys), .rst_n(rst_n), .dram(dram), .cfg(cfg), .err(err));
  initial forever #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hold the request until it is taken, then time its pulse against the last one
  task automatic issue(input sdrt_pkg::sdrt_kind_t k, output int gap);
    int n;
    @(posedge clk_sys) req <= {1'b1, k};
    n = 0;
    do begin @(negedge clk_sys); n++; end while (req_ready !== 1'b1 && n < 2000);
    check("request taken", req_ready, 1'b1);
    @(posedge clk_sys) req <= '0;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (dram.cmd_valid !== 1'b1 && n < 50);
    check("pulse seen", dram.cmd_valid, 1'b1);
    check("pulse kind", 16'(dram.cmd_kind), 16'(k));
    gap = cyc - last;
    last = cyc;
  endtask
  // Reset levels, a refused command, then the first command after CKE rise
  task automatic t_reset();
    int g;
    check("cke in reset", dram.cke, 1'b0);
    check("clk_en in reset", dram.clk_en, 1'b1);
    check("pulse in reset", dram.cmd_valid, 1'b0);
    @(posedge clk_sys) req <= {1'b1, sdrt_pkg::K_NODLL};
    rst_n <= 1'b1;
    @(negedge clk_sys) check("ready before exit", req_ready, 1'b0);
    issue(sdrt_pkg::K_RST_EXIT, g);
    check("cke after reset exit", dram.cke, 1'b1);
    issue(sdrt_pkg::K_NODLL, g);
    check("reset exit gap", 16'(g), 16'(XPR));
  endtask
  // A mode write must wait out the whole short calibration
  task automatic t_zq();
    int g;
    issue(sdrt_pkg::K_ZQS, g);
    issue(sdrt_pkg::K_ZQMRS, g);
    check("short zq gap", 16'(g), 16'h0080);
  endtask
  // Self refresh round trip, then one command kind after the exit
  task automatic t_sr(input logic ab, input logic pe, input logic [3:0] pl,
    input sdrt_pkg::sdrt_kind_t k, input int exp);
    int g;
    @(posedge clk_sys) cfg <= {ab, pe, pl};
    issue(sdrt_pkg::K_SR_ENTER, g);
    check("cke in self refresh", dram.cke, 1'b0);
    while (dram.clk_en !== 1'b0 && cyc - last < 40) @(negedge clk_sys);
    check("clock hold", 16'(cyc - last), 16'(CKSRE + (pe ? pl : 0)));
    issue(sdrt_pkg::K_SR_EXIT, g);
    check("cke after exit", dram.cke, 1'b1);
    check("clock after exit", dram.clk_en, 1'b1);
    issue(k, g);
    check("exit gap", 16'(g), 16'(exp));
  endtask
  // Power-down keeps the clock running
  task automatic t_pd();
    int g;
    issue(sdrt_pkg::K_PD_ENTER, g);
    check("cke in power down", dram.cke, 1'b0);
    repeat (8) @(negedge clk_sys);
    check("clock in power down", dram.clk_en, 1'b1);
    issue(sdrt_pkg::K_PD_EXIT, g);
    check("cke after power down", dram.cke, 1'b1);
  endtask
  // Watchdog well above the few hundred cycles the run needs
  initial begin
    repeat (6000) @(posedge clk_sys);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    t_reset();
    t_zq();
    t_sr(1'b0, 1'b0, 4'h0, sdrt_pkg::K_NODLL, XS);
    t_sr(1'b1, 1'b0, 4'h0, sdrt_pkg::K_NODLL, XS4);
    t_sr(1'b0, 1'b0, 4'h0, sdrt_pkg::K_ZQS, XS);
    t_sr(1'b1, 1'b0, 4'h0, sdrt_pkg::K_ZQMRS, XS4);
    t_sr(1'b0, 1'b1, 4'h3, sdrt_pkg::K_DLL, DLLK);
    t_pd();
    check("memory faults", err, 16'h0000);
    test_done();
  end
endmodule
